// file: rtl/eic_ctrl.v
// Overview of operation
// - Edge code 00 disables fast detection and ignores the input for power-down.
// - Group level bits 1:0 break ties within one priority; 3 wins, 0 loses.
// - Priority level bits 5:2 rank the source; Fh highest, 0h lowest.
// - Enable bit 6 gates each source into arbitration independently.
// - Request flag bit 7 shows a pending request and is software writable.
// - Auxiliary-3 control register shares the layout, resets to zero, upper byte unused.
`timescale 1ns/100ps
`default_nettype none
`include "eic_defs.vh"

module eic_ctrl
(
    // Clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // Wishbone slave
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [15:0] adr_i,
    input  wire [1:0]  sel_i,
    input  wire [15:0] dat_i,
    output reg  [15:0] dat_o,
    output reg         ack_o,
    // Interrupt inputs
    input  wire [7:0]  pin_irq_i,
    input  wire [7:0]  alt_irq_i,
    input  wire        aux3_event_i,
    // Arbitration and power-down results
    output reg         irq_req_o,
    output reg  [3:0]  irq_src_o,
    output reg  [3:0]  irq_level_o,
    output reg         pd_enter_ok_o,
    output reg         pd_wake_o
);

    //------------------------------------------------------------
    // Registers
    //------------------------------------------------------------
    reg  [15:0] ext_irq_edge_control;
    reg  [15:0] ext_irq_source_select;
    reg  [7:0]  ic [0:8];               // 0..7 fast inputs, 8 is auxiliary-3
    reg  [7:0]  pin_s1, pin_s2, alt_s1, alt_s2;
    reg         aux_s1, aux_s2, aux_s3;
    reg  [7:0]  prev_in;
    wire [7:0]  fast_irq_input;         // Selected source per fast input
    wire [7:0]  edge_hit;
    wire [7:0]  pd_ok;
    wire [7:0]  pd_wk;
    wire        aux_edge = aux_s2 & ~aux_s3;
    integer     i;                      // Loop index of the register process
    integer     j;                      // Loop index of the arbitration process

    // Source select combine function
    function comb_src;
        input [1:0] ss;
        input       p;
        input       a;
        begin
            case (ss)
                `EIC_SS_PIN: comb_src = p;
                `EIC_SS_ALT: comb_src = a;
                `EIC_SS_OR:  comb_src = p | a;
                default:     comb_src = p & a;
            endcase
        end
    endfunction

    //------------------------------------------------------------
    // Input synchronisers and selected sources
    //------------------------------------------------------------
    always @(posedge clk_i)
    begin
        pin_s1 <= pin_irq_i;
        pin_s2 <= pin_s1;
        alt_s1 <= alt_irq_i;
        alt_s2 <= alt_s1;
        aux_s1 <= aux3_event_i;
        aux_s2 <= aux_s1;
        aux_s3 <= aux_s2;
        prev_in <= fast_irq_input;
    end

    // Per-input edge and power-down decode
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1)
        begin : g_in
            wire [1:0] es = ext_irq_edge_control[2*g+1:2*g];
            // One continuous driver per bit keeps the vector single-driven
            assign fast_irq_input[g] = comb_src(ext_irq_source_select[2*g+1:2*g],
                                                pin_s2[g], alt_s2[g]);
            // Edge select per code; code 00 never fires
            assign edge_hit[g] = ((es == `EIC_ES_RISE) & fast_irq_input[g] & ~prev_in[g])
                               | ((es == `EIC_ES_FALL) & ~fast_irq_input[g] & prev_in[g])
                               | ((es == `EIC_ES_ANY) & (fast_irq_input[g] ^ prev_in[g]));
            // Power-down entry allowed at inactive level, ignored when off
            assign pd_ok[g] = (es == `EIC_ES_OFF) | (es == `EIC_ES_ANY)
                            | ((es == `EIC_ES_RISE) & ~fast_irq_input[g])
                            | ((es == `EIC_ES_FALL) & fast_irq_input[g]);
            // Wake on active level, or on any change for code 11
            assign pd_wk[g] = ((es == `EIC_ES_RISE) & fast_irq_input[g])
                            | ((es == `EIC_ES_FALL) & ~fast_irq_input[g])
                            | ((es == `EIC_ES_ANY) & (fast_irq_input[g] ^ prev_in[g]));
        end
    endgenerate

    //------------------------------------------------------------
    // Bus decode
    //------------------------------------------------------------
    wire       req    = cyc_i & stb_i & ~ack_o;
    wire       wr     = req & we_i;
    wire [15:0] src0_base = `EIC_OFF_SRC0;
    wire       hit_ic = (adr_i[15:4] == src0_base[15:4]) & ~adr_i[0];
    wire [3:0] ic_idx = {1'b0, adr_i[3:1]};

    // Register writes and request flags; hardware set wins over clear
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ext_irq_edge_control  <= `EIC_EDGE_RST;
            ext_irq_source_select <= `EIC_SEL_RST;
            for (i = 0; i < 9; i = i + 1)
                ic[i] <= `EIC_IC_RST;
        end
        else
        begin
            if (wr && adr_i == `EIC_OFF_EDGE)
            begin
                if (sel_i[0]) ext_irq_edge_control[7:0]  <= dat_i[7:0];
                if (sel_i[1]) ext_irq_edge_control[15:8] <= dat_i[15:8];
            end
            if (wr && adr_i == `EIC_OFF_SEL)
            begin
                if (sel_i[0]) ext_irq_source_select[7:0]  <= dat_i[7:0];
                if (sel_i[1]) ext_irq_source_select[15:8] <= dat_i[15:8];
            end
            for (i = 0; i < 8; i = i + 1)
            begin
                if (wr && hit_ic && ic_idx == i && sel_i[0])
                    ic[i] <= dat_i[7:0];
                if (edge_hit[i])
                    ic[i][`EIC_IR_BIT] <= 1'b1;
            end
            // Upper byte of the auxiliary-3 register is not stored
            if (wr && adr_i == `EIC_OFF_AUX3 && sel_i[0])
                ic[8] <= dat_i[7:0];
            if (aux_edge)
                ic[8][`EIC_IR_BIT] <= 1'b1;
        end
    end

    // Read mux and single-cycle acknowledge
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_o <= 1'b0;
            dat_o <= 16'h0000;
        end
        else
        begin
            ack_o <= req;
            if (adr_i == `EIC_OFF_EDGE)
                dat_o <= ext_irq_edge_control;
            else if (adr_i == `EIC_OFF_SEL)
                dat_o <= ext_irq_source_select;
            else if (adr_i == `EIC_OFF_AUX3)
                dat_o <= {8'h00, ic[8]};
            else if (hit_ic)
                dat_o <= {8'h00, ic[ic_idx[2:0]]};
            else if (adr_i == `EIC_OFF_STATUS)
                dat_o <= {8'h00, fast_irq_input};
            else
                dat_o <= 16'h0000;
        end
    end

    //------------------------------------------------------------
    // Arbitration: highest {level, group} among enabled requests
    //------------------------------------------------------------
    reg  [6:0] best;
    reg  [3:0] best_src;
    reg        any;
    reg  [6:0] key;
    always @*
    begin
        best     = 7'h00;
        best_src = 4'h0;
        any      = 1'b0;
        key      = 7'h00;
        for (j = 0; j < 9; j = j + 1)
        begin
            key = {1'b1, ic[j][5:0]};
            if (ic[j][`EIC_IR_BIT] && ic[j][`EIC_IE_BIT] && key > best)
            begin
                best     = key;
                best_src = j[3:0];
                any      = 1'b1;
            end
        end
    end

    // Registered outputs
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            irq_req_o     <= 1'b0;
            irq_src_o     <= 4'h0;
            irq_level_o   <= 4'h0;
            pd_enter_ok_o <= 1'b1;
            pd_wake_o     <= 1'b0;
        end
        else
        begin
            irq_req_o     <= any;
            irq_src_o     <= best_src;
            irq_level_o   <= best[5:2];
            pd_enter_ok_o <= &pd_ok;
            pd_wake_o     <= |pd_wk;
        end
    end

endmodule
`default_nettype wire

// file: rtl/eic_defs.vh
`ifndef EIC_DEFS_VH
`define EIC_DEFS_VH
// Word offsets (byte addresses on the Wishbone bus)
`define EIC_OFF_EDGE     16'hf1c0
`define EIC_OFF_SEL      16'hf1da
`define EIC_OFF_AUX3     16'hf19e
`define EIC_OFF_SRC0     16'hf180
`define EIC_OFF_STATUS   16'hf1a0
// Interrupt control field positions
`define EIC_GROUP_LEVEL_LSB     0
`define EIC_PRIORITY_LEVEL_LSB     2
`define EIC_IE_BIT       6
`define EIC_IR_BIT       7
// Reset values
`define EIC_EDGE_RST     16'h0000
`define EIC_SEL_RST      16'h0000
`define EIC_IC_RST       8'h00
// Edge field codes
`define EIC_ES_OFF       2'h0
`define EIC_ES_RISE      2'h1
`define EIC_ES_FALL      2'h2
`define EIC_ES_ANY       2'h3
// Source select codes
`define EIC_SS_PIN       2'h0
`define EIC_SS_ALT       2'h1
`define EIC_SS_OR        2'h2
`define EIC_SS_AND       2'h3
`endif

// file: tb/eic_ctrl_monitor.sv
`timescale 1ns/100ps
`default_nettype none
// ----
// Bus and arbitration checks
// ----
module eic_ctrl_monitor
(
    // Watched ports
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [15:0] adr_i,
    input wire logic [15:0] dat_o,
    input wire logic        ack_o,
    input wire logic        irq_req_o,
    input wire logic [3:0]  irq_src_o,
    input wire logic        pd_enter_ok_o,
    input wire logic        pd_wake_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Taken request and taken read
    wire logic tk = cyc_i && stb_i && !ack_o;
    wire logic rq = tk && !we_i;
    a_ack_next: assert property (tk |=> ack_o) else $error("no ack");
    a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("long ack");
    a_ack_cause: assert property (!tk |=> !ack_o) else $error("stray ack");
    a_hole_zero: assert property (rq && adr_i == 16'h0100 |=> dat_o == 16'h0000)
        else $error("hole read");
    a_aux3_upper: assert property (rq && adr_i == 16'hf19e |=> dat_o[15:8] == 8'h00)
        else $error("aux3 upper");
    a_ic_upper: assert property (rq && adr_i[15:4] == 12'hf18 |=> dat_o[15:8] == 8'h00)
        else $error("ic upper");
    a_src_range: assert property (irq_req_o |-> irq_src_o <= 4'h8)
        else $error("bad source");
    a_reset_idle: assert property (disable iff (1'h0) rst_i |=> !irq_req_o
        && pd_enter_ok_o && !pd_wake_o) else $error("reset state");
endmodule
bind eic_ctrl eic_ctrl_monitor u_mon (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_o,
    .ack_o, .irq_req_o, .irq_src_o, .pd_enter_ok_o, .pd_wake_o);
`default_nettype wire

// file: tb/eic_src_model.sv
`timescale 1ns/100ps
`default_nettype none
module eic_src_model
(
    // Clock and wanted levels
    input  wire logic       clk_i,
    input  wire logic [7:0] pin_w_i,
    input  wire logic [7:0] alt_w_i,
    input  wire logic       aux_w_i,
    // Levels at the block
    output var  logic [7:0] pin_o = 8'h00,
    output var  logic [7:0] alt_o = 8'h00,
    output var  logic       aux_o = 1'h0
);
    // Sources move just after an edge, like real pins
    always @(posedge clk_i)
    begin
        pin_o <= pin_w_i;
        alt_o <= alt_w_i;
        aux_o <= aux_w_i;
    end
endmodule
`default_nettype wire

// file: tb/external_interrupt_control_test.sv
`timescale 1ns/100ps
`default_nettype none
`include "eic_defs.vh"
module external_interrupt_control_test;
    logic        clk_i = 1'h0, rst_i = 1'h1, cyc_i = 1'h0, stb_i = 1'h0, we_i = 1'h0;
    logic        aux_w = 1'h0, aux_s, ack_o, irq_req_o, pd_enter_ok_o, pd_wake_o, p, a, v;
    logic [15:0] adr_i = 16'h0, dat_i = 16'h0, dat_o, rd, r, ic;
    logic [7:0]  pin_w = 8'h0, alt_w = 8'h0, pin_s, alt_s;
    logic [3:0]  irq_src_o, irq_level_o;
    logic [2:0]  k;
    logic [1:0]  sel_i = 2'h3, c, s;
    logic [15:0] regs [4] = '{`EIC_OFF_EDGE, `EIC_OFF_SEL, `EIC_OFF_AUX3, `EIC_OFF_SRC0};
    int          bad_count = 0, checks = 0, ncyc = 0;
    eic_src_model SRC (.clk_i, .pin_w_i(pin_w), .alt_w_i(alt_w), .aux_w_i(aux_w),
        .pin_o(pin_s), .alt_o(alt_s), .aux_o(aux_s));
    eic_ctrl DUT (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
        .pin_irq_i(pin_s), .alt_irq_i(alt_s), .aux3_event_i(aux_s), .irq_req_o, .irq_src_o,
        .irq_level_o, .pd_enter_ok_o, .pd_wake_o);
    // Clock and hang guard
    initial forever #25 clk_i = ~clk_i;
    always @(posedge clk_i)
    begin
        ncyc++;
        if (ncyc == 20000)
        begin
            bad_count++;
            tally_and_finish;
        end
    end
    task tally_and_finish;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("mismatch %s exp %h got %h", n, e, g);
        end
    endtask
    // Classic single Wishbone cycle, waits for ack
    task wb(input logic w, input logic [15:0] ad, input logic [15:0] d);
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'h3, w, ad, d};
        @(posedge clk_i);
        while (ack_o !== 1'h1)
            @(posedge clk_i);
        rd = dat_o;
        {cyc_i, stb_i} <= 2'h0;
    endtask
    // Level seen by a fast input for each source choice
    function automatic logic sv(input logic [1:0] m, input logic x, input logic y);
        return m == 2'h0 ? x : m == 2'h1 ? y : m == 2'h2 ? (x | y) : (x & y);
    endfunction
    // Expected {wake, entry allowed} for one input at a steady level
    function automatic logic [1:0] pd(input logic [1:0] m, input logic x);
        return m == 2'h1 ? {x, !x} : m == 2'h2 ? {!x, x} : 2'h1;
    endfunction
    initial
    begin
        void'($urandom(32'h8818));
        repeat (6) @(posedge clk_i);
        rst_i <= 1'h0;
        // Reset values, random read-back, hole, lane gating
        for (int i = 0; i < 4; i++)
        begin
            wb(1'h0, regs[i], 16'h0);
            chk("reset", 16'h0, rd);
            r = 16'($urandom);
            wb(1'h1, regs[i], r);
            wb(1'h0, regs[i], 16'h0);
            chk("rw", i < 2 ? r : {8'h0, r[7:0]}, rd);
            wb(1'h1, regs[i], 16'h0);
        end
        wb(1'h0, 16'h0100, 16'h0);
        chk("hole", 16'h0, rd);
        sel_i <= 2'h2;
        wb(1'h1, `EIC_OFF_SRC0, 16'h00ff);
        sel_i <= 2'h3;
        wb(1'h0, `EIC_OFF_SRC0, 16'h0);
        chk("lane", 16'h0, rd);
        // Every edge code against every source choice
        for (int j = 0; j < 16; j++)
        begin
            {c, s} = j[3:0];
            k = 3'($urandom);
            {p, a} = 2'($urandom);
            v = sv(s, p, a);
            ic = `EIC_OFF_SRC0 + {12'h0, k, 1'h0};
            wb(1'h1, `EIC_OFF_EDGE, {14'h0, c} << (2 * k));
            wb(1'h1, `EIC_OFF_SEL, {14'h0, s} << (2 * k));
            wb(1'h1, ic, 16'h0040);
            {pin_w, alt_w} <= {8'(p) << k, 8'(a) << k};
            repeat (8) @(posedge clk_i);
            chk("req", 16'(v & c[0]), 16'(irq_req_o));
            if (c == 2'h1)
                chk("wake", {14'h0, v, !v}, {14'h0, pd_wake_o, pd_enter_ok_o});
            chk("pd", {14'h0, pd(c, v)}, {14'h0, pd_wake_o, pd_enter_ok_o});
            wb(1'h0, ic, 16'h0);
            chk("rise", {8'h0, v & c[0], 7'h40}, rd);
            wb(1'h1, ic, 16'h0040);
            {pin_w, alt_w} <= 16'h0;
            repeat (8) @(posedge clk_i);
            chk("pd low", {14'h0, pd(c, 1'h0)}, {14'h0, pd_wake_o, pd_enter_ok_o});
            wb(1'h0, ic, 16'h0);
            chk("fall", 16'(v & c[1]), 16'(rd[7]));
            wb(1'h1, ic, 16'h0);
        end
        wb(1'h1, `EIC_OFF_EDGE, 16'h0);
        // Arbitration by group, enable, level, then aux3
        wb(1'h1, `EIC_OFF_SRC0 + 16'h2, 16'h00e5);
        wb(1'h1, `EIC_OFF_SRC0 + 16'h4, 16'h00e7);
        repeat (3) @(posedge clk_i);
        chk("tie", 16'h0092, {irq_level_o, irq_src_o});
        wb(1'h1, `EIC_OFF_SRC0 + 16'h4, 16'h00a7);
        repeat (3) @(posedge clk_i);
        chk("mask", 16'h0091, {irq_level_o, irq_src_o});
        wb(1'h1, `EIC_OFF_SRC0 + 16'h6, 16'h00e8);
        repeat (3) @(posedge clk_i);
        chk("level", 16'h00a3, {irq_level_o, irq_src_o});
        wb(1'h1, `EIC_OFF_AUX3, 16'hffff);
        repeat (3) @(posedge clk_i);
        chk("aux3", 16'h00f8, {irq_level_o, irq_src_o});
        wb(1'h1, `EIC_OFF_AUX3, 16'h0040);
        aux_w <= 1'h1;
        repeat (8) @(posedge clk_i);
        wb(1'h0, `EIC_OFF_AUX3, 16'h0);
        chk("event", 16'h00c0, rd);
        tally_and_finish;
    end
endmodule
`default_nettype wire
